// File: voltage_detect_pkg.sv
package voltage_detect_pkg;

   // bus geometry
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;

   // register byte addresses
   localparam logic [ADDR_W-1:0] CTRL_OFFSET = 4'h0;
   localparam logic [ADDR_W-1:0] FLAG_OFFSET = 4'h4;

   // voltage_detect_control field positions
   localparam int DIR_BIT = 7;
   localparam int UNUSED_BIT = 6;
   localparam int STABLE_BIT = 5;
   localparam int ENABLE_BIT = 4;
   localparam int LEVEL_MSB = 3;
   localparam int LEVEL_LSB = 0;
   localparam int LEVEL_W = LEVEL_MSB - LEVEL_LSB + 1;
   localparam logic [7:0] CTRL_RESET = 8'h05;
   localparam logic [LEVEL_W-1:0] LEVEL_EXTERNAL = 4'hf;
   localparam logic [LEVEL_W-1:0] LEVEL_MAX_INTERNAL = 4'he;

   // peripheral_flag_register field position
   localparam int EVENT_BIT = 2;
   localparam logic FLAG_RESET = 1'b0;

   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // reference settling interval; least time, so rounded up
   localparam int CLK_PERIOD_NS = 10;
   localparam int STABILIZE_TIME_NS = 20000;
   localparam int STABILIZE_CYCLES = (STABILIZE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int COUNT_W = 12;

   typedef enum logic [1:0] {
      DET_OFF = 2'b00,
      DET_SETTLING = 2'b01,
      DET_ARMED = 2'b10
   } detector_state_type;

endpackage

// File: supply_voltage_detect_ctrl.sv
// Summary of operation
// [RQ1] direction 1: event when supply at or above selected trip level
// [RQ2] direction 0: event when supply at or below selected trip level
// [RQ3] control bit 6 reads zero and ignores writes
// [RQ4] reference stable flag is read-only: 1 stable, 0 no events possible
// [RQ5] on every enable, hold stable flag low for settling interval, then set
// [RQ6] no event flag setting while reference stable flag is clear
// [RQ7] enable 1 powers and runs detector, enable 0 disables it fully
// [RQ8] 4-bit trip level picks one of 15 levels, 0000 lowest, 1110 highest
// [RQ9] trip level 1111 routes the external trip input to the comparator
// [RQ10] comparator trip in selected direction sets the event flag
// [RQ11] reset returns control register to reset state, detector disabled
// [RQ12] software clears event flag after enabling, stale event may remain
// [RQ13] detector runs in sleep; trip then sets flag and wakes device
// [RQ14] comparator output synchronised; event flag sticky until software clears
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps

module supply_voltage_detect_ctrl #(
   parameter int STAB_CYCLES = voltage_detect_pkg::STABILIZE_CYCLES
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic awvalid,
   output logic awready,
   input wire logic [voltage_detect_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [voltage_detect_pkg::DATA_W-1:0] wdata,
   input wire logic [voltage_detect_pkg::STRB_W-1:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [voltage_detect_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [voltage_detect_pkg::DATA_W-1:0] rdata,
   output logic [1:0] rresp,
   input wire logic cmp_at_or_above,
   input wire logic cmp_at_or_below,
   input wire logic sleep_mode,
   output logic detector_enable,
   output logic [voltage_detect_pkg::LEVEL_W-1:0] trip_level_select,
   output logic external_input_select,
   output logic detect_event_flag,
   output logic wake_request
);
   import voltage_detect_pkg::*;

   if (STAB_CYCLES < 1 || STAB_CYCLES > (1 << COUNT_W)) begin : g_bad_stab
      $error("STAB_CYCLES out of range for the settling counter");
   end

   localparam logic [COUNT_W-1:0] STAB_LAST = COUNT_W'(STAB_CYCLES - 1);

   // write channel holding
   logic aw_held;
   logic w_held;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [DATA_W-1:0] w_data_q;
   logic [STRB_W-1:0] w_strb_q;
   logic do_write;
   logic wr_ctrl;
   logic wr_flag;
   logic wr_mapped;

   // control fields
   logic direction_select;

   // detector sequencing
   detector_state_type state;
   detector_state_type next_state;
   logic [COUNT_W-1:0] stab_count;
   logic reference_stable_flag;

   // comparator synchronisers
   logic above_meta;
   logic above_sync;
   logic below_meta;
   logic below_sync;
   logic trip_met;
   logic event_set;

   // read decode
   logic [DATA_W-1:0] next_rdata;
   logic [1:0] next_rresp;
   logic rd_was_ctrl;

   // awprot and arprot carry no meaning here; every access is accepted
   assign do_write = aw_held && w_held && !bvalid;
   assign wr_mapped = (aw_addr_q == CTRL_OFFSET) || (aw_addr_q == FLAG_OFFSET);
   assign wr_ctrl = do_write && (aw_addr_q == CTRL_OFFSET) && w_strb_q[0];
   assign wr_flag = do_write && (aw_addr_q == FLAG_OFFSET) && w_strb_q[0];

   // write address channel
   always_ff @(posedge clk) begin
      if (rst) begin
         awready <= 1'b1;
         aw_held <= 1'b0;
         aw_addr_q <= '0;
      end else if (clk_en) begin
         if (awvalid && awready) begin
            awready <= 1'b0;
            aw_held <= 1'b1;
            aw_addr_q <= awaddr;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end else if (bvalid && bready) begin
            awready <= 1'b1;
         end
      end
   end

   // write data channel
   always_ff @(posedge clk) begin
      if (rst) begin
         wready <= 1'b1;
         w_held <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (clk_en) begin
         if (wvalid && wready) begin
            wready <= 1'b0;
            w_held <= 1'b1;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end else if (do_write) begin
            w_held <= 1'b0;
         end else if (bvalid && bready) begin
            wready <= 1'b1;
         end
      end
   end

   // write response
   always_ff @(posedge clk) begin
      if (rst) begin
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (clk_en) begin
         if (do_write) begin
            bvalid <= 1'b1;
            bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // control register; the stable bit and bit 6 have no storage here
   always_ff @(posedge clk) begin
      if (rst) begin
         direction_select <= CTRL_RESET[DIR_BIT]; // RQ11
         detector_enable <= CTRL_RESET[ENABLE_BIT]; // RQ11
         trip_level_select <= CTRL_RESET[LEVEL_MSB:LEVEL_LSB]; // RQ11
         external_input_select <= (CTRL_RESET[LEVEL_MSB:LEVEL_LSB] == LEVEL_EXTERNAL);
      end else if (clk_en && wr_ctrl) begin
         direction_select <= w_data_q[DIR_BIT];
         detector_enable <= w_data_q[ENABLE_BIT]; // RQ7
         trip_level_select <= w_data_q[LEVEL_MSB:LEVEL_LSB]; // RQ8
         external_input_select <= (w_data_q[LEVEL_MSB:LEVEL_LSB] == LEVEL_EXTERNAL); // RQ9
      end
   end

   // settling sequence; a write sequence always shows enable low for at
   // least one cycle, so every re-enable passes through DET_OFF
   always_comb begin
      next_state = state;
      case (state)
         DET_OFF: begin
            if (detector_enable) begin
               next_state = DET_SETTLING; // RQ5
            end
         end
         DET_SETTLING: begin
            if (!detector_enable) begin
               next_state = DET_OFF; // RQ7
            end else if (stab_count == STAB_LAST) begin
               next_state = DET_ARMED; // RQ5
            end
         end
         DET_ARMED: begin
            if (!detector_enable) begin
               next_state = DET_OFF; // RQ7
            end
         end
         default: begin
            next_state = DET_OFF;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state <= DET_OFF;
      end else if (clk_en) begin
         state <= next_state;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         stab_count <= '0;
      end else if (clk_en) begin
         if (state == DET_SETTLING && next_state == DET_SETTLING) begin
            stab_count <= stab_count + 1'b1;
         end else begin
            stab_count <= '0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         reference_stable_flag <= 1'b0;
      end else if (clk_en) begin
         reference_stable_flag <= (next_state == DET_ARMED); // RQ4 RQ5
      end
   end

   // comparator outputs are asynchronous to clk
   always_ff @(posedge clk) begin
      if (rst) begin
         above_meta <= 1'b0;
         above_sync <= 1'b0;
         below_meta <= 1'b0;
         below_sync <= 1'b0;
      end else if (clk_en) begin
         above_meta <= cmp_at_or_above; // RQ14
         above_sync <= above_meta; // RQ14
         below_meta <= cmp_at_or_below; // RQ14
         below_sync <= below_meta; // RQ14
      end
   end

   // equality raises both comparator outputs, so either direction trips there
   assign trip_met = direction_select ? above_sync : below_sync; // RQ1 RQ2
   assign event_set = reference_stable_flag && detector_enable && trip_met; // RQ6 RQ10

   // set wins over a clearing write in the same cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         detect_event_flag <= FLAG_RESET;
      end else if (clk_en) begin
         if (event_set) begin
            detect_event_flag <= 1'b1; // RQ10
         end else if (wr_flag) begin
            detect_event_flag <= w_data_q[EVENT_BIT]; // RQ14
         end
      end
   end

   // wake follows the flag so a sleeping core sees a level, not a pulse
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_request <= 1'b0;
      end else if (clk_en) begin
         wake_request <= sleep_mode && (event_set || detect_event_flag); // RQ13
      end
   end

   always_comb begin
      next_rdata = '0;
      next_rresp = RESP_OKAY;
      if (araddr == CTRL_OFFSET) begin
         next_rdata[DIR_BIT] = direction_select;
         next_rdata[UNUSED_BIT] = 1'b0; // RQ3
         next_rdata[STABLE_BIT] = reference_stable_flag; // RQ4
         next_rdata[ENABLE_BIT] = detector_enable;
         next_rdata[LEVEL_MSB:LEVEL_LSB] = trip_level_select;
      end else if (araddr == FLAG_OFFSET) begin
         next_rdata[EVENT_BIT] = detect_event_flag;
      end else begin
         next_rresp = RESP_SLVERR;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
         rd_was_ctrl <= 1'b0;
      end else if (clk_en) begin
         if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= next_rresp;
            rd_was_ctrl <= (araddr == CTRL_OFFSET);
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_high_trip_sets: assert property ( // RQ1
      clk_en && direction_select && above_sync && reference_stable_flag && detector_enable
      |=> detect_event_flag
   ) else $error("high trip did not set event flag");
   chk_low_trip_sets: assert property ( // RQ2
      clk_en && !direction_select && below_sync && reference_stable_flag && detector_enable
      |=> detect_event_flag
   ) else $error("low trip did not set event flag");
   chk_unused_bit_zero: assert property ( // RQ3
      rvalid && rd_was_ctrl |-> !rdata[UNUSED_BIT] && (rdata[DATA_W-1:8] == '0)
   ) else $error("control read shows bits that must be zero");
   chk_stable_needs_enable: assert property ( // RQ4
      reference_stable_flag |-> detector_enable || $past(detector_enable)
   ) else $error("stable flag set with detector disabled");
   chk_settle_length: assert property ( // RQ5
      $rose(reference_stable_flag) |-> $past(stab_count) == STAB_LAST
   ) else $error("stable flag rose before settling interval ended");
   chk_enable_clears_stable: assert property ( // RQ5
      clk_en && $rose(detector_enable) |-> !reference_stable_flag ##1 !reference_stable_flag
   ) else $error("stable flag not held low after enable");
   chk_no_unstable_event: assert property ( // RQ6
      clk_en && !reference_stable_flag && !detect_event_flag && !wr_flag
      |=> !detect_event_flag
   ) else $error("event flag set before reference stable");
   chk_disable_full: assert property ( // RQ7
      clk_en && !detector_enable |=> !reference_stable_flag && state == DET_OFF
   ) else $error("detector still running while disabled");
   chk_tap_follows_write: assert property ( // RQ8
      clk_en && wr_ctrl |=> trip_level_select == $past(w_data_q[LEVEL_MSB:LEVEL_LSB])
   ) else $error("trip level not taken from write");
   chk_external_route: assert property ( // RQ9
      external_input_select == (trip_level_select == LEVEL_EXTERNAL)
   ) else $error("external input select mismatches trip level");
   chk_reset_control: assert property ( // RQ11
      $past(rst) |-> !detector_enable && trip_level_select == CTRL_RESET[LEVEL_MSB:LEVEL_LSB]
   ) else $error("control not at reset state");
   chk_sleep_wake: assert property ( // RQ13
      clk_en && sleep_mode && detect_event_flag |=> wake_request
   ) else $error("no wake request for flag in sleep");
   chk_flag_sticky: assert property ( // RQ14
      clk_en && detect_event_flag && !wr_flag |=> detect_event_flag
   ) else $error("event flag dropped without software clear");
   chk_set_beats_clear: assert property ( // RQ14
      clk_en && event_set && wr_flag |=> detect_event_flag
   ) else $error("clearing write lost a coincident event");

   cov_high_event: cover property (
      direction_select && $rose(detect_event_flag)
   );
   cov_low_event: cover property (
      !direction_select && $rose(detect_event_flag)
   );
   cov_external_event: cover property (
      external_input_select && $rose(detect_event_flag)
   );
   cov_clear_collision: cover property (
      clk_en && event_set && wr_flag && !w_data_q[EVENT_BIT]
   );

endmodule // supply_voltage_detect_ctrl

// File: supply_comparator_model.sv
`timescale 1ns/100ps

module supply_comparator_model (
   input wire logic clk,
   input wire logic detector_enable,
   input wire logic [voltage_detect_pkg::LEVEL_W-1:0] trip_level_select,
   input wire logic external_input_select,
   input wire logic [4:0] supply_lvl,
   input wire logic [4:0] ext_lvl,
   output logic cmp_at_or_above,
   output logic cmp_at_or_below
);
   import voltage_detect_pkg::*;
   logic [4:0] threshold;
   logic toggle = 1'b0;
   // an unpowered comparator gives no trustworthy answer, so it wanders
   always_ff @(posedge clk) begin
      toggle <= !toggle;
   end
   always_comb begin
      threshold = external_input_select ? ext_lvl : {1'b0, trip_level_select};
      if (!detector_enable) begin
         cmp_at_or_above = toggle;
         cmp_at_or_below = !toggle;
      end else begin
         cmp_at_or_above = supply_lvl >= threshold;
         cmp_at_or_below = supply_lvl <= threshold;
      end
   end
endmodule // supply_comparator_model

// File: tb_top.sv
`timescale 1ns/100ps

module tb_top;
   import voltage_detect_pkg::*;
   typedef struct {logic [7:0] wr; logic [7:0] rd; logic ext;} row_type;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic clk_en = 1'b1;
   logic sleep_mode = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
   logic [DATA_W-1:0] wdata = '0;
   logic [STRB_W-1:0] wstrb = '0;
   logic awready, wready, bvalid, arready, rvalid, above, below;
   logic det_en, ext_sel, flag, wake;
   logic [1:0] bresp, rresp, resp;
   logic [DATA_W-1:0] rdata, rd;
   logic [LEVEL_W-1:0] level;
   logic [4:0] supply = 5'h00, ext_lvl = 5'h00;
   int fail_count = 0;
   int samples_checked = 0;
   // bits 6 and 5 are offered on write and must never come back
   row_type rows [6] = '{'{8'hef, 8'h8f, 1'b1}, '{8'h6e, 8'h0e, 1'b0}, '{8'h20, 8'h00, 1'b0},
      '{8'h87, 8'h87, 1'b0}, '{8'h4f, 8'h0f, 1'b1}, '{8'h00, 8'h00, 1'b0}};

   always #5 clk = ~clk;

   supply_voltage_detect_ctrl #(.STAB_CYCLES(12)) supply_voltage_detect_ctrl_i (
      .clk(clk), .rst(rst), .clk_en(clk_en),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'b000),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
      .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'b000),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .cmp_at_or_above(above), .cmp_at_or_below(below), .sleep_mode(sleep_mode),
      .detector_enable(det_en), .trip_level_select(level),
      .external_input_select(ext_sel), .detect_event_flag(flag), .wake_request(wake));

   supply_comparator_model supply_comparator_model_i (
      .clk(clk), .detector_enable(det_en), .trip_level_select(level),
      .external_input_select(ext_sel), .supply_lvl(supply), .ext_lvl(ext_lvl),
      .cmp_at_or_above(above), .cmp_at_or_below(below));

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // no local limit: a lost answer is left to the watchdog, which ends the run
   task automatic axi_write(input logic [3:0] a, input logic [7:0] d, input logic [3:0] s);
      @(posedge clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready === 1'b1) awvalid <= 1'b0;
         if (wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [3:0] a);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      rd = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   initial begin
      cyc(20000);
      fail_count++;
      tally_and_finish();
   end

   initial begin
      cyc(16);
      rst <= 1'b0;
      check("outs reset", 32'({det_en, level, ext_sel, flag, wake}), 32'h28);
      check("bus reset", 32'({awready, wready, arready, bvalid, rvalid}), 32'h1c);
      axi_read(CTRL_OFFSET);
      check("ctrl reset", rd, 32'(CTRL_RESET));
      axi_read(FLAG_OFFSET);
      check("flag reset", rd, 32'h0);
      foreach (rows[i]) begin
         axi_write(CTRL_OFFSET, rows[i].wr, 4'hf);
         check("bresp row", 32'(resp), 32'(RESP_OKAY));
         axi_read(CTRL_OFFSET);
         check("rresp row", 32'(resp), 32'(RESP_OKAY));
         check("ctrl row", rd, 32'(rows[i].rd));
         check("ext row", 32'({ext_sel, level}), 32'({rows[i].ext, rows[i].wr[3:0]}));
      end
      for (int i = 0; i < 16; i++) begin
         axi_write(CTRL_OFFSET, 8'(i), 4'hf);
         cyc(2);
         check("level", 32'({ext_sel, level}), 32'({i == 15, 4'(i)}));
      end
      axi_write(4'h8, 8'hff, 4'hf);
      check("bresp unmapped", 32'(resp), 32'(RESP_SLVERR));
      axi_read(4'h8);
      check("read unmapped", rd, 32'h0);
      check("rresp unmapped", 32'(resp), 32'(RESP_SLVERR));
      axi_write(CTRL_OFFSET, 8'h8a, 4'h0);
      axi_read(CTRL_OFFSET);
      check("strobe off", rd, 32'h0f);
      // trip level equals supply during settling: nothing may be flagged
      supply <= 5'd5;
      axi_write(CTRL_OFFSET, 8'h95, 4'hf);
      axi_read(CTRL_OFFSET);
      check("settling ctrl", rd, 32'h95);
      // an ungated trip would show by now, well before the reference is stable
      cyc(6);
      check("settling flag", 32'(flag), 32'h0);
      cyc(40);
      check("flag above", 32'(flag), 32'h1);
      axi_read(CTRL_OFFSET);
      check("stable ctrl", rd, 32'hb5);
      supply <= 5'd4;
      cyc(4);
      axi_write(FLAG_OFFSET, 8'h00, 4'hf);
      cyc(8);
      check("flag cleared", 32'(flag), 32'h0);
      clk_en <= 1'b0;
      supply <= 5'd6;
      cyc(8);
      check("frozen flag", 32'(flag), 32'h0);
      clk_en <= 1'b1;
      cyc(2);
      supply <= 5'd4;
      cyc(8);
      check("flag sticky", 32'(flag), 32'h1);
      axi_read(FLAG_OFFSET);
      check("flag reg", rd, 32'h4);
      axi_write(FLAG_OFFSET, 8'h00, 4'hf);
      axi_write(CTRL_OFFSET, 8'h05, 4'hf);
      cyc(40);
      check("disabled", 32'({det_en, flag}), 32'h0);
      axi_read(CTRL_OFFSET);
      check("disabled ctrl", rd, 32'h05);
      supply <= 5'd6;
      axi_write(CTRL_OFFSET, 8'h15, 4'hf);
      axi_read(CTRL_OFFSET);
      check("reenable ctrl", rd, 32'h15);
      cyc(40);
      check("no flag above", 32'(flag), 32'h0);
      supply <= 5'd5;
      cyc(8);
      check("flag below", 32'(flag), 32'h1);
      axi_write(CTRL_OFFSET, 8'h05, 4'hf);
      supply <= 5'd12;
      ext_lvl <= 5'd10;
      axi_write(CTRL_OFFSET, 8'h9f, 4'hf);
      // the flag still holds the last event, so it is cleared once enabled
      axi_write(FLAG_OFFSET, 8'h00, 4'hf);
      sleep_mode <= 1'b1;
      check("no wake", 32'({flag, wake}), 32'h0);
      cyc(40);
      check("ext wake", 32'({ext_sel, flag, wake}), 32'h7);
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      sleep_mode <= 1'b0;
      check("outs rerst", 32'({det_en, level, ext_sel, flag, wake}), 32'h28);
      axi_read(CTRL_OFFSET);
      check("ctrl rerst", rd, 32'(CTRL_RESET));
      tally_and_finish();
   end
endmodule // tb_top
